// [inc/ims_cfg.svh]
// Purpose: addresses, field positions, reset values and timing counts of the status block
// Assumes: 10 MHz aclk, 32-bit register bus
// Notes: definitions only
`ifndef IMS_CFG_SVH
`define IMS_CFG_SVH

`define IMS_ADDR_CTRL 32'h4000_3400
`define IMS_ADDR_STAT 32'h4000_3404

`define IMS_ST_SCL 14
`define IMS_ST_SDA 13
`define IMS_ST_TXUF 12
`define IMS_ST_OWNSTOP 11
`define IMS_ST_BUSBUSY 10
`define IMS_ST_RXOF 9
`define IMS_ST_DONE 8
`define IMS_ST_DNACK 7
`define IMS_ST_MASTER_BUSY_FLAG 6
`define IMS_ST_ARBITRATION_LOST_FLAG 5
`define IMS_ST_ANACK 4
`define IMS_ST_RXREQ 3
`define IMS_ST_TXREQ 2
`define IMS_ST_TXLVL_HI 1
`define IMS_ST_TXLVL_LO 0

`define IMS_CT_IEN_CMP 8
`define IMS_CT_IEN_ACK 7
`define IMS_CT_IEN_ARBITRATION_LOST_FLAG 6
`define IMS_CT_IEN_MTX 5
`define IMS_CT_IEN_MRX 4
`define IMS_CT_MEN 0
`define IMS_CTRL_WMASK 16'h01F1

`define IMS_STAT_RESET 16'h6000
`define IMS_CTRL_RESET 16'h0000

`define IMS_FIFO_DEPTH 2'h2
`define IMS_TXLVL_EMPTY 2'h0
`define IMS_TXLVL_ONE 2'h2
`define IMS_TXLVL_FULL 2'h3

`define IMS_CLK_PERIOD_NS 100
`define IMS_GLITCH_NS 50
`define IMS_GLITCH_CYC_RAW ((`IMS_GLITCH_NS + `IMS_CLK_PERIOD_NS - 1) / `IMS_CLK_PERIOD_NS)
`define IMS_GLITCH_CYC ((`IMS_GLITCH_CYC_RAW < 1) ? 1 : `IMS_GLITCH_CYC_RAW)

`endif

// [inc/ims_pkg.sv]
// Purpose: shared types of the two-wire master status block
// Assumes: nothing
// Notes: constants live in ims_cfg.svh
package ims_pkg;
  typedef enum logic [1:0] {
    IMS_RESP_OKAY = 2'b00,
    IMS_RESP_SLVERR = 2'b10
  } ims_resp_type;

  typedef logic [15:0] ims_reg_type;
  typedef logic [1:0] ims_count_type;
endpackage

// [inc/ims_line_if.sv]
// Purpose: carries one filtered bus line and its edges
// Assumes: single aclk domain
// Notes: rise and fall are one-cycle pulses aligned with level changes
`timescale 1ns/10ps
interface ims_line_if;
  logic level;
  logic rise;
  logic fall;
  modport filt (output level, output rise, output fall);
  modport user (input level, input rise, input fall);
endinterface

// [rtl/ims_line_filter.sv]
// Purpose: synchronise and glitch-filter one two-wire bus line
// Assumes: pin is asynchronous to aclk, idles high
// Notes: a change is accepted once stable for GLITCH_CYC samples
`timescale 1ns/10ps
`include "ims_cfg.svh"
module ims_line_filter #(
  parameter int GLITCH_CYC = `IMS_GLITCH_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin,
  ims_line_if.filt line
);
  logic meta_q;
  logic sync_q;
  logic level_q;
  logic rise_q;
  logic fall_q;
  logic [7:0] cnt_q;
  logic accept;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
    end
  end

  assign accept = (sync_q != level_q) && (cnt_q == 8'(GLITCH_CYC - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 8'h00;
    end else if (sync_q == level_q || accept) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // undriven line is pulled up, so the filtered level starts high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_q <= 1'b1;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      rise_q <= accept && sync_q;
      fall_q <= accept && !sync_q;
      if (accept) begin
        level_q <= sync_q;
      end
    end
  end

  assign line.level = level_q;
  assign line.rise = rise_q;
  assign line.fall = fall_q;
endmodule // ims_line_filter

// [rtl/ims_status.sv]
// Purpose: status, event flags and interrupt of a two-wire bus master
// Assumes: engine inputs are on aclk; line pins are asynchronous
// Notes: registers reached over AXI4-Lite
//
// Summary of operation
// - status bit 14 shows filtered clock line
// - status bit 13 shows filtered data line
// - underflow flag bit 12, only with tx enable
// - own-stop flag bit 11, own stops only
// - own stop on done, underflow, overflow, nack
// - bus-busy bit 10 set start, cleared stop
// - rx overflow flag bit 9 on full push
// - done flag bit 8 on any stop, enabled
// - done flag interrupts when completion enable set
// - data nack flag bit 7, interrupt enabled
// - master-busy bit 6 while servicing transaction
// - arbitration lost flag bit 5, interrupt enabled
// - address nack flag bit 4, interrupt enabled
// - rx request bit 3 while rx holds data
// - tx request bit 2, write and not full
// - tx level bits 1:0 as 00/10/11
// - interrupt enables at control bits 8..4
// - both master FIFOs hold two bytes
// - enable bit 0 gates master clock
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/10ps
`include "ims_cfg.svh"
module ims_status (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scl_pin,
  input wire logic sda_pin,
  input wire logic eng_busy,
  input wire logic eng_stop_driven,
  input wire logic eng_xfer_done,
  input wire logic eng_tx_empty_end,
  input wire logic eng_rx_push,
  input wire logic eng_addr_nack,
  input wire logic eng_data_nack,
  input wire logic eng_arb_lost,
  input wire logic eng_dir_read,
  input wire ims_pkg::ims_count_type tx_fifo_count,
  input wire ims_pkg::ims_count_type rx_fifo_count,
  output logic master_clk_en,
  output logic stop_request,
  output logic irq
);
  ims_line_if scl_line ();
  ims_line_if sda_line ();

  ims_line_filter u_scl_filter (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(scl_pin),
    .line(scl_line)
  );

  ims_line_filter u_sda_filter (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(sda_pin),
    .line(sda_line)
  );

  ims_pkg::ims_reg_type ctrl_q;
  logic [31:0] awaddr_q;
  logic aw_have_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic w_have_q;
  logic bvalid_q;
  ims_pkg::ims_resp_type bresp_q;
  logic rvalid_q;
  ims_pkg::ims_resp_type rresp_q;
  logic [31:0] rdata_q;
  logic stat_read;
  logic do_write;

  logic txuf_q;
  logic ownstop_q;
  logic busbusy_q;
  logic rxof_q;
  logic done_q;
  logic dnack_q;
  logic master_busy_flag_q;
  logic arbitration_lost_flag_q;
  logic anack_q;
  logic rxreq_q;
  logic txreq_q;
  logic [1:0] txlvl_q;
  logic stop_req_q;
  logic irq_q;

  logic start_det;
  logic stop_det;
  logic txuf_set;
  logic rxof_set;
  logic ien_cmp;
  logic ien_ack;
  logic ien_arbitration_lost_flag;
  logic ien_mtx;
  logic ien_mrx;
  ims_pkg::ims_reg_type stat_word;

  assign ien_cmp = ctrl_q[`IMS_CT_IEN_CMP];
  assign ien_ack = ctrl_q[`IMS_CT_IEN_ACK];
  assign ien_arbitration_lost_flag = ctrl_q[`IMS_CT_IEN_ARBITRATION_LOST_FLAG];
  assign ien_mtx = ctrl_q[`IMS_CT_IEN_MTX];
  assign ien_mrx = ctrl_q[`IMS_CT_IEN_MRX];

  // write channel: address and data are taken independently, held until both arrive
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign do_write = aw_have_q && w_have_q && !bvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      awaddr_q <= 32'h0000_0000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (do_write) begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= ims_pkg::IMS_RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      // status is read-only: a write there is accepted and ignored
      if (awaddr_q == `IMS_ADDR_CTRL || awaddr_q == `IMS_ADDR_STAT) begin
        bresp_q <= ims_pkg::IMS_RESP_OKAY;
      end else begin
        bresp_q <= ims_pkg::IMS_RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // control: only enables and master enable are writable, the rest reads zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `IMS_CTRL_RESET;
    end else if (do_write && awaddr_q == `IMS_ADDR_CTRL) begin
      if (wstrb_q[0]) begin
        ctrl_q[7:0] <= wdata_q[7:0] & 8'(`IMS_CTRL_WMASK);
      end
      if (wstrb_q[1]) begin
        ctrl_q[15:8] <= wdata_q[15:8] & 8'(`IMS_CTRL_WMASK >> 8);
      end
    end
  end

  assign master_clk_en = ctrl_q[`IMS_CT_MEN];

  // read channel: one outstanding read, data registered
  assign s_axi_arready = !rvalid_q;
  assign stat_read = s_axi_arvalid && s_axi_arready && s_axi_araddr == `IMS_ADDR_STAT;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q <= ims_pkg::IMS_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      if (s_axi_araddr == `IMS_ADDR_CTRL) begin
        rresp_q <= ims_pkg::IMS_RESP_OKAY;
        rdata_q <= {16'h0000, ctrl_q};
      end else if (s_axi_araddr == `IMS_ADDR_STAT) begin
        rresp_q <= ims_pkg::IMS_RESP_OKAY;
        rdata_q <= {16'h0000, stat_word};
      end else begin
        rresp_q <= ims_pkg::IMS_RESP_SLVERR;
        rdata_q <= 32'h0000_0000;
      end
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // bus conditions from filtered lines: data edge while clock stays high
  assign start_det = sda_line.fall && scl_line.level;
  assign stop_det = sda_line.rise && scl_line.level;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busbusy_q <= 1'b0;
    end else if (start_det) begin
      busbusy_q <= 1'b1;
    end else if (stop_det) begin
      busbusy_q <= 1'b0;
    end
  end

  assign txuf_set = eng_tx_empty_end && ien_mtx;
  assign rxof_set = eng_rx_push && rx_fifo_count == `IMS_FIFO_DEPTH;

  // read-to-clear flags: a set in the clearing cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txuf_q <= 1'b0;
      ownstop_q <= 1'b0;
      rxof_q <= 1'b0;
      done_q <= 1'b0;
      dnack_q <= 1'b0;
      arbitration_lost_flag_q <= 1'b0;
      anack_q <= 1'b0;
    end else begin
      txuf_q <= txuf_set || (txuf_q && !stat_read);
      ownstop_q <= eng_stop_driven || (ownstop_q && !stat_read);
      rxof_q <= rxof_set || (rxof_q && !stat_read);
      done_q <= (stop_det && master_clk_en) || (done_q && !stat_read);
      dnack_q <= eng_data_nack || (dnack_q && !stat_read);
      arbitration_lost_flag_q <= eng_arb_lost || (arbitration_lost_flag_q && !stat_read);
      anack_q <= eng_addr_nack || (anack_q && !stat_read);
    end
  end

  // a stop is requested of the sequencer on done, underflow, overflow or either nack, not on arbitration loss
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop_req_q <= 1'b0;
    end else begin
      stop_req_q <= eng_xfer_done || eng_tx_empty_end || rxof_set || eng_addr_nack || eng_data_nack;
    end
  end

  assign stop_request = stop_req_q;

  // live conditions, registered so the status word is glitch free
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      master_busy_flag_q <= 1'b0;
      rxreq_q <= 1'b0;
      txreq_q <= 1'b0;
      txlvl_q <= `IMS_TXLVL_EMPTY;
    end else begin
      master_busy_flag_q <= eng_busy && !eng_arb_lost;
      rxreq_q <= rx_fifo_count != 2'h0;
      txreq_q <= !eng_dir_read && tx_fifo_count != `IMS_FIFO_DEPTH;
      unique case (tx_fifo_count)
        2'h0: txlvl_q <= `IMS_TXLVL_EMPTY;
        2'h1: txlvl_q <= `IMS_TXLVL_ONE;
        default: txlvl_q <= `IMS_TXLVL_FULL;
      endcase
    end
  end

  always_comb begin
    stat_word = 16'h0000;
    stat_word[`IMS_ST_SCL] = scl_line.level;
    stat_word[`IMS_ST_SDA] = sda_line.level;
    stat_word[`IMS_ST_TXUF] = txuf_q;
    stat_word[`IMS_ST_OWNSTOP] = ownstop_q;
    stat_word[`IMS_ST_BUSBUSY] = busbusy_q;
    stat_word[`IMS_ST_RXOF] = rxof_q;
    stat_word[`IMS_ST_DONE] = done_q;
    stat_word[`IMS_ST_DNACK] = dnack_q;
    stat_word[`IMS_ST_MASTER_BUSY_FLAG] = master_busy_flag_q;
    stat_word[`IMS_ST_ARBITRATION_LOST_FLAG] = arbitration_lost_flag_q;
    stat_word[`IMS_ST_ANACK] = anack_q;
    stat_word[`IMS_ST_RXREQ] = rxreq_q;
    stat_word[`IMS_ST_TXREQ] = txreq_q;
    stat_word[`IMS_ST_TXLVL_HI:`IMS_ST_TXLVL_LO] = txlvl_q;
  end

  // own-stop raises nothing by itself; level follows flags until they are read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (done_q && ien_cmp)
        || ((dnack_q || anack_q) && ien_ack)
        || (arbitration_lost_flag_q && ien_arbitration_lost_flag)
        || (txreq_q && ien_mtx)
        || (rxreq_q && ien_mrx);
    end
  end

  assign irq = irq_q;
endmodule // ims_status

// [verif/ims_status_monitor.sv]
// Purpose: concurrent checks on the status block ports
// Assumes: control address and data are offered together
// Notes: ctl_q shadows the control enables
`timescale 1ns/10ps
`include "ims_cfg.svh"
module ims_status_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic eng_xfer_done,
  input wire logic eng_tx_empty_end,
  input wire logic eng_rx_push,
  input wire logic eng_addr_nack,
  input wire logic eng_data_nack,
  input wire logic eng_arb_lost,
  input wire logic eng_dir_read,
  input wire ims_pkg::ims_count_type tx_fifo_count,
  input wire ims_pkg::ims_count_type rx_fifo_count,
  input wire logic master_clk_en,
  input wire logic stop_request,
  input wire logic irq
);
  logic [8:0] ctl_q;
  logic cause;
  assign cause = eng_xfer_done | eng_tx_empty_end | eng_addr_nack | eng_data_nack | (eng_rx_push && rx_fifo_count >= 2'h2);
  // shadow lags nothing: takes the word on the joint handshake edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_q <= 9'h000;
    end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == `IMS_ADDR_CTRL) begin
      ctl_q <= s_axi_wdata[8:0] & 9'h1f1;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_stop_cause: assert property (cause |=> stop_request) else $error("stop request missing");
  chk_stop_source: assert property (stop_request |-> $past(cause)) else $error("stop request without cause");
  chk_men_follow: assert property (ctl_q[0] != master_clk_en |-> ##[1:2] ctl_q[0] == master_clk_en)
    else $error("master clock enable not following control");
  chk_arb_irq: assert property (eng_arb_lost && ctl_q[6] |-> ##[1:3] irq) else $error("arbitration irq missing");
  chk_anack_irq: assert property (eng_addr_nack && ctl_q[7] |-> ##[1:3] irq) else $error("address nack irq missing");
  chk_dnack_irq: assert property (eng_data_nack && ctl_q[7] |-> ##[1:3] irq) else $error("data nack irq missing");
  chk_rxreq_irq: assert property (rx_fifo_count != 2'h0 && ctl_q[4] |-> ##[1:3] irq) else $error("rx irq missing");
  chk_txreq_irq: assert property (!eng_dir_read && tx_fifo_count < 2'h2 && ctl_q[5] |-> ##[1:3] irq)
    else $error("tx irq missing");
  chk_irq_quiet: assert property (ctl_q[8:4] == 5'h00 [*4] |-> !irq) else $error("irq with all enables off");
  cover property (stop_request);
  cover property (irq && ctl_q[8]);
  cover property (eng_arb_lost && ctl_q[6]);
endmodule // ims_status_monitor

bind ims_status ims_status_monitor u_ims_status_monitor (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready,
  .eng_xfer_done, .eng_tx_empty_end, .eng_rx_push, .eng_addr_nack, .eng_data_nack, .eng_arb_lost,
  .eng_dir_read, .tx_fifo_count, .rx_fifo_count, .master_clk_en, .stop_request, .irq
);

// [verif/ims_bus_model.sv]
// Purpose: another party on the two-wire bus making start and stop
// Assumes: both lines pulled high, 800 ns bit time
// Notes: lines rest high outside frames, no free-running clock
`timescale 1ns/10ps
module ims_bus_model (
  output logic scl,
  output logic sda
);
  localparam int QTR = 200;
  initial begin
    scl = 1'h1;
    sda = 1'h1;
  end
  // offset keeps pin edges away from the sampling edge
  task automatic start_cond();
    #30 sda = 1'h0;
    #QTR scl = 1'h0;
    #(2 * QTR);
  endtask
  task automatic stop_cond();
    #30 sda = 1'h0;
    #QTR scl = 1'h1;
    #QTR sda = 1'h1;
    #(3 * QTR);
  endtask
endmodule // ims_bus_model

// [verif/ims_status_test.sv]
// Purpose: self-checking bench of the two-wire master status block
// Assumes: bus partner drives the line pins asynchronously
// Notes: checker is bound in the monitor file
`timescale 1ns/10ps
`include "ims_cfg.svh"
module ims_status_test;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic eng_busy = 1'h0, eng_dir_read = 1'h1, bb = 1'h0;
  logic [6:0] ev = 7'h00;
  ims_pkg::ims_count_type tx_cnt = 2'h0, rx_cnt = 2'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, scl_line, sda_line;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [4:0] hsv;
  int n_fail = 0, checks = 0;
  assign hsv = {irq, s_axi_bvalid, s_axi_rvalid, s_axi_arready, s_axi_awready & s_axi_wready};
  always #50 aclk = ~aclk;
  ims_bus_model u_ims_bus_model (.scl(scl_line), .sda(sda_line));
  ims_status u_ims_status (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .scl_pin(scl_line), .sda_pin(sda_line), .eng_busy, .eng_stop_driven(ev[1]), .eng_xfer_done(ev[6]),
    .eng_tx_empty_end(ev[0]), .eng_rx_push(ev[2]), .eng_addr_nack(ev[5]), .eng_data_nack(ev[3]),
    .eng_arb_lost(ev[4]), .eng_dir_read, .tx_fifo_count(tx_cnt), .rx_fifo_count(rx_cnt),
    .master_clk_en(), .stop_request(), .irq);
  task automatic wrap_up();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // handshakes are judged on settled values half a cycle before the edge
  task automatic wait_hi(input int i);
    for (int n = 0; n < 200; n++) begin
      @(negedge aclk);
      if (hsv[i] === 1'h1) return;
    end
    cmp("wait_timeout", 32'h1, 32'h0);
    wrap_up();
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    wait_hi(0);
    @(posedge aclk);
    s_axi_awvalid <= 1'h0;
    s_axi_wvalid <= 1'h0;
    s_axi_bready <= 1'h1;
    wait_hi(3);
    resp = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    wait_hi(1);
    @(posedge aclk);
    s_axi_arvalid <= 1'h0;
    s_axi_rready <= 1'h1;
    wait_hi(2);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'h0;
  endtask
  task automatic pulse(input logic [6:0] k);
    @(posedge aclk);
    ev <= k;
    @(posedge aclk);
    ev <= 7'h00;
  endtask
  function automatic logic [15:0] live();
    logic [1:0] t;
    t = (tx_cnt == 2'h0) ? 2'h0 : (tx_cnt == 2'h1) ? 2'h2 : 2'h3;
    return {1'h0, scl_line, sda_line, 2'h0, bb, 3'h0, eng_busy, 2'h0, rx_cnt != 2'h0, !eng_dir_read && tx_cnt < 2'h2, t};
  endfunction
  function automatic logic [15:0] fmask(input int k, input logic txen);
    case (k)
      0: return txen ? 16'h1000 : 16'h0000;
      1: return 16'h0800;
      2: return 16'h0200;
      3: return 16'h0080;
      4: return 16'h0020;
      5: return 16'h0010;
      default: return 16'h0000;
    endcase
  endfunction
  task automatic st(input string nm, input logic [15:0] m);
    logic [31:0] d;
    rd(`IMS_ADDR_STAT, d);
    cmp(nm, {16'h0000, live() | m}, d);
  endtask
  initial begin
    logic [31:0] d, c;
    void'($urandom(32'h924e_0d02));
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    rd(`IMS_ADDR_STAT, d);
    cmp("status_reset", 32'h0000_6000, d);
    rd(32'h4000_3408, d);
    cmp("unmapped_resp", 32'h0000_0002, {30'h0, resp});
    cmp("unmapped_data", 32'h0000_0000, d);
    for (int i = 0; i < 4; i++) begin
      c = $urandom;
      wr(`IMS_ADDR_CTRL, c);
      rd(`IMS_ADDR_CTRL, d);
      cmp("control", c & 32'h0000_01f1, d);
    end
    wr(32'h4000_3408, 32'h0000_00ff);
    cmp("unmapped_wr_resp", 32'h0000_0002, {30'h0, resp});
    wr(`IMS_ADDR_STAT, 32'hffff_ffff);
    cmp("status_wr_resp", 32'h0000_0000, {30'h0, resp});
    st("status_ro", 16'h0000);
    @(posedge aclk);
    rx_cnt <= 2'h2;
    for (int p = 0; p < 2; p++) begin
      c = p ? 32'h0000_01f1 : 32'h0000_0001;
      wr(`IMS_ADDR_CTRL, c);
      for (int k = 0; k < 7; k++) begin
        pulse(7'(1 << k));
        st("flag_set", fmask(k, c[5]));
        st("flag_clear", 16'h0000);
      end
    end
    for (int i = 0; i < 8; i++) begin
      @(posedge aclk);
      tx_cnt <= 2'($urandom_range(2));
      rx_cnt <= 2'($urandom_range(2));
      eng_dir_read <= 1'($urandom);
      eng_busy <= 1'($urandom);
      st("status_live", 16'h0000);
    end
    wr(`IMS_ADDR_CTRL, 32'h0000_0000);
    u_ims_bus_model.start_cond();
    bb = 1'h1;
    st("busy_start", 16'h0000);
    u_ims_bus_model.stop_cond();
    bb = 1'h0;
    st("stop_disabled", 16'h0000);
    wr(`IMS_ADDR_CTRL, 32'h0000_0101);
    u_ims_bus_model.start_cond();
    u_ims_bus_model.stop_cond();
    wait_hi(4);
    st("done_flag", 16'h0100);
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    cmp("irq_done_read", 32'h0, {31'h0, irq});
    wr(`IMS_ADDR_CTRL, 32'h0000_0041);
    pulse(7'h10);
    wait_hi(4);
    wr(`IMS_ADDR_CTRL, 32'h0000_0001);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    cmp("irq_masked", 32'h0, {31'h0, irq});
    st("arb_kept", 16'h0020);
    wr(`IMS_ADDR_CTRL, 32'h0000_0011);
    @(posedge aclk);
    rx_cnt <= 2'h1;
    wait_hi(4);
    @(posedge aclk);
    rx_cnt <= 2'h0;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    cmp("irq_rx_off", 32'h0, {31'h0, irq});
    wrap_up();
  end
endmodule // ims_status_test
